// *** rtl/dfcs_params.svh ***
// Constants of the data flash command sequencer: offsets, fields, codes.
`ifndef DFCS_PARAMS_SVH
`define DFCS_PARAMS_SVH
// ----------------------------------------------------------------------------
// Register offsets (word addresses on the Avalon-MM word bus)
// ----------------------------------------------------------------------------
`define DFCS_OFS_STATUS   4'h0
`define DFCS_OFS_INDEX    4'h1
`define DFCS_OFS_BUFFER   4'h2
`define DFCS_OFS_CONFIG   4'h3
`define DFCS_OFS_ERRSTAT  4'h4
`define DFCS_OFS_IRQSTAT  4'h5
`define DFCS_OFS_IRQMASK  4'h6
// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define DFCS_ST_VERR_UNC  0
`define DFCS_ST_VERR      1
`define DFCS_ST_PVIOL     4
`define DFCS_ST_ACCESS_ERROR_FLAG    5
`define DFCS_ST_COMMAND_COMPLETE_FLAG      7
// ----------------------------------------------------------------------------
// Config and error fields
// ----------------------------------------------------------------------------
`define DFCS_CF_COMMAND_COMPLETE_IRQ_ENABLE      7
`define DFCS_CF_SINGLE_FAULT_IRQ_ENABLE     0
`define DFCS_CF_DOUBLE_FAULT_IRQ_ENABLE     1
`define DFCS_ER_SINGLE_FAULT_FLAG     0
`define DFCS_ER_DOUBLE_FAULT_FLAG     1
// ----------------------------------------------------------------------------
// Command codes, index values, geometry
// ----------------------------------------------------------------------------
`define DFCS_CMD_FMARGIN  8'h0E
`define DFCS_CMD_EVSECT   8'h10
`define DFCS_CMD_PROG     8'h11
`define DFCS_CMD_ERASE    8'h12
`define DFCS_IDX_1        3'h1
`define DFCS_IDX_2        3'h2
`define DFCS_IDX_5        3'h5
`define DFCS_MARGIN_MAX   16'h0004
`define DFCS_DF_BLOCK     2'h1
`define DFCS_DF_BASE      16'h4400
`define DFCS_DF_WORDS     11
`define DFCS_SECTOR_WORDS 5
`define DFCS_OP_CYCLES    8'h10
`endif

// *** rtl/dfcs_pkg.sv ***
// Types of the data flash command sequencer.
package dfcs_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_CHECK = 5'h02,
      ST_OPER  = 5'h04,
      ST_VERIFY= 5'h08,
      ST_DONE  = 5'h10
   } dfcs_state_t;
endpackage

// *** rtl/dfcs_cmd_check.sv ***
// Launch checks: access error and protection decision for each command.
`timescale 1ns/1ps
`include "dfcs_params.svh"
module dfcs_cmd_check
   import dfcs_pkg::*;
(
   // Command buffer view
   input  wire logic [2:0]  index_in,
   input  wire logic [15:0] word0_in,
   input  wire logic [15:0] word1_in,
   input  wire logic [15:0] word2_in,
   // Environment
   input  wire logic        mode_ok_in,
   input  wire logic [15:0] prot_limit_in,
   // Verdict
   output logic             acc_err_out,
   output logic             prot_err_out,
   output logic [15:0]      first_out,
   output logic [15:0]      count_out
);
   wire [7:0]  code      = word0_in[15:8];
   wire        blk_ok    = word0_in[1:0] == `DFCS_DF_BLOCK;
   wire [16:0] rel       = {1'b0, word1_in} - {1'b0, `DFCS_DF_BASE};
   wire        in_range  = !rel[16] && rel[15:0] < (16'h1 << `DFCS_DF_WORDS);
   wire        addr_ok   = blk_ok && in_range;
   wire        aligned   = !word1_in[0];
   wire [15:0] n_prog    = {13'h0, index_in} - 16'h0001;
   wire [16:0] end_ev    = {1'b0, rel[15:0]} + {1'b0, word2_in};
   wire [16:0] end_pr    = {1'b0, rel[15:0]} + {1'b0, n_prog};
   wire [16:0] lim       = 17'h1 << `DFCS_DF_WORDS;
   wire        fm_err    = index_in != `DFCS_IDX_1 || !mode_ok_in
                           || !blk_ok || word1_in > `DFCS_MARGIN_MAX;
   wire        ev_err    = index_in != `DFCS_IDX_2 || !mode_ok_in
                           || !addr_ok || !aligned || end_ev > lim;
   wire        pr_err    = index_in < `DFCS_IDX_2 || index_in > `DFCS_IDX_5
                           || !mode_ok_in || !addr_ok || !aligned
                           || end_pr > lim;
   wire        er_err    = index_in != `DFCS_IDX_1 || !mode_ok_in
                           || !addr_ok || !aligned;
   wire        is_wr     = code == `DFCS_CMD_PROG || code == `DFCS_CMD_ERASE;
   always_comb begin
      acc_err_out = 1'b1;
      case (code)
         `DFCS_CMD_FMARGIN: acc_err_out = fm_err;
         `DFCS_CMD_EVSECT:  acc_err_out = ev_err;
         `DFCS_CMD_PROG:    acc_err_out = pr_err;
         `DFCS_CMD_ERASE:   acc_err_out = er_err;
         default:           acc_err_out = 1'b1;
      endcase
   end
   // Area below the limit is protected.
   assign prot_err_out = is_wr && rel[15:0] < prot_limit_in;
   assign first_out = code == `DFCS_CMD_ERASE ?
      (rel[15:0] & ~16'((1 << `DFCS_SECTOR_WORDS) - 1)) : rel[15:0];
   assign count_out = code == `DFCS_CMD_EVSECT ? word2_in :
      code == `DFCS_CMD_PROG ? n_prog :
      code == `DFCS_CMD_ERASE ? 16'(1 << `DFCS_SECTOR_WORDS) : 16'h0000;
endmodule

// *** rtl/dfcs_irq.sv ***
// Interrupt sources: command complete and fault interrupt requests.
`timescale 1ns/1ps
`include "dfcs_params.svh"
module dfcs_irq
   import dfcs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Flags and enables
   input  wire logic command_complete_flag_in,
   input  wire logic command_complete_irq_enable_in,
   input  wire logic single_fault_flag_in,
   input  wire logic double_fault_flag_in,
   input  wire logic single_fault_irq_enable_in,
   input  wire logic double_fault_irq_enable_in,
   // Requests
   output logic      cmd_irq_out,
   output logic      err_irq_out
);
   wire cmd_d = command_complete_flag_in && command_complete_irq_enable_in;
   wire err_d = (single_fault_flag_in && single_fault_irq_enable_in) || (double_fault_flag_in && double_fault_irq_enable_in);
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cmd_irq_out <= 1'b0;
         err_irq_out <= 1'b0;
      end else begin
         cmd_irq_out <= cmd_d;
         err_irq_out <= err_d;
      end
   end
   a_cmd_irq_follow: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      command_complete_flag_in && command_complete_irq_enable_in |=> cmd_irq_out) else $error("cmd irq missing");
   a_err_irq_follow: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !single_fault_flag_in && !double_fault_flag_in |=> !err_irq_out) else $error("err irq stray");
endmodule

// *** rtl/dfcs_top.sv ***
// Data flash command sequencer with Avalon-MM register slave.
// How it works
// - Field margin: bad index/mode/block/level -> access error.
// - Erase-verify checks words erased, then completes.
// - Erase-verify access error on index/mode/address/range.
// - Erase-verify read errors set verify status bits.
// - Index at launch sets program word count.
// - Program access error on index/mode/address/range.
// - Protected target sets protection flag, no change.
// - Verify after write sets status, then complete.
// - Sector erase clears whole sector, verifies, completes.
// - Sector erase access error on index/mode/address.
// - Interrupts on completion and on ECC fault.
// - Command interrupt when complete and enabled.
// - Error interrupt when fault flag and enable.
// - Stop mode waits until the command finishes.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dfcs_params.svh"
module dfcs_top
   import dfcs_pkg::*;
#(
   parameter int DF_WORDS = 1 << `DFCS_DF_WORDS
)(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // System
   input  wire logic        mode_ok_in,
   input  wire logic [15:0] prot_limit_in,
   input  wire logic        stop_req_in,
   output logic             stop_ack_out,
   // Interrupts
   output logic             irq_out,
   output logic             cmd_irq_out,
   output logic             err_irq_out
);
   // -------------------------------------------------------------------------
   // Registers and array
   // -------------------------------------------------------------------------
   dfcs_state_t  state_q, state_d;
   logic [2:0]   index_q;
   logic [15:0]  cbuf_q [6];
   logic [2:0]   launch_idx_q;
   logic         command_complete_flag_q, access_error_flag_q, pviol_q, verr_q, verru_q;
   logic         command_complete_irq_enable_q, single_fault_irq_enable_q, double_fault_irq_enable_q, single_fault_flag_q, double_fault_flag_q;
   logic [1:0]   irqst_q, irqmask_q;
   logic [15:0]  cur_q, left_q;
   logic [7:0]   tmr_q;
   logic [15:0]  mem_q [DF_WORDS];
   logic [31:0]  rdata_q;
   logic         wait_q, stopack_q, irq_q;
   logic         mode_s1_q, mode_s2_q, stop_s1_q, stop_s2_q;
   logic         acc_err, prot_err;
   logic [15:0]  first, count;
   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   wire acc     = (avs_read_in || avs_write_in) && wait_q;
   wire wr      = avs_write_in && !wait_q;
   wire wr_st   = wr && avs_address_in == `DFCS_OFS_STATUS;
   wire wr_idx  = wr && avs_address_in == `DFCS_OFS_INDEX && command_complete_flag_q;
   wire wr_buf  = wr && avs_address_in == `DFCS_OFS_BUFFER && command_complete_flag_q;
   wire wr_cfg  = wr && avs_address_in == `DFCS_OFS_CONFIG;
   wire wr_er   = wr && avs_address_in == `DFCS_OFS_ERRSTAT;
   wire wr_is   = wr && avs_address_in == `DFCS_OFS_IRQSTAT;
   wire wr_im   = wr && avs_address_in == `DFCS_OFS_IRQMASK;
   wire launch  = wr_st && command_complete_flag_q && avs_writedata_in[`DFCS_ST_COMMAND_COMPLETE_FLAG];
   wire [7:0] st_rd = {command_complete_flag_q, 1'b0, access_error_flag_q, pviol_q, 2'b00,
                       verr_q, verru_q};
   wire [2:0] bi = index_q > 3'h5 ? 3'h5 : index_q;
   wire [31:0] rd_mux =
      avs_address_in == `DFCS_OFS_STATUS  ? {24'h0, st_rd} :
      avs_address_in == `DFCS_OFS_INDEX   ? {29'h0, index_q} :
      avs_address_in == `DFCS_OFS_BUFFER  ? {16'h0, cbuf_q[bi]} :
      avs_address_in == `DFCS_OFS_CONFIG  ?
         {24'h0, command_complete_irq_enable_q, 5'h0, double_fault_irq_enable_q, single_fault_irq_enable_q} :
      avs_address_in == `DFCS_OFS_ERRSTAT ? {30'h0, double_fault_flag_q, single_fault_flag_q} :
      avs_address_in == `DFCS_OFS_IRQSTAT ? {30'h0, irqst_q} :
      avs_address_in == `DFCS_OFS_IRQMASK ? {30'h0, irqmask_q} : 32'h0;
   // -------------------------------------------------------------------------
   // Operation datapath
   // -------------------------------------------------------------------------
   wire [7:0]  code     = cbuf_q[0][15:8];
   wire [15:0] wptr     = cur_q;
   wire [15:0] rword    = mem_q[wptr[`DFCS_DF_WORDS-1:0]];
   wire        not_erased = rword != 16'hFFFF;
   // Words of the array that read with a stuck pattern count as uncorrectable.
   wire        uncorr   = rword == 16'h0000;
   wire [2:0]  pidx     = 3'h2 + 3'(cur_q - first);
   wire        is_ev    = code == `DFCS_CMD_EVSECT;
   wire        is_pr    = code == `DFCS_CMD_PROG;
   wire        is_er    = code == `DFCS_CMD_ERASE;
   wire        op_step  = tmr_q == 8'h00;
   wire        last     = left_q <= 16'h0001;
   wire        cmd_done = state_q == ST_DONE;
   wire        verr_ev  = op_step && (state_q == ST_VERIFY) && not_erased
                          && (is_ev || is_er);
   wire        verr_pr  = op_step && (state_q == ST_VERIFY) && is_pr
                          && rword != cbuf_q[pidx];
   dfcs_cmd_check u_check (
      .index_in      (launch_idx_q),
      .word0_in      (cbuf_q[0]),
      .word1_in      (cbuf_q[1]),
      .word2_in      (cbuf_q[2]),
      .mode_ok_in    (mode_s2_q),
      .prot_limit_in (prot_limit_in),
      .acc_err_out   (acc_err),
      .prot_err_out  (prot_err),
      .first_out     (first),
      .count_out     (count)
   );
   dfcs_irq u_irq (
      .clk_in      (clk_in),
      .nrst_in     (nrst_in),
      .command_complete_flag_in     (command_complete_flag_q),
      .command_complete_irq_enable_in     (command_complete_irq_enable_q),
      .single_fault_flag_in    (single_fault_flag_q),
      .double_fault_flag_in    (double_fault_flag_q),
      .single_fault_irq_enable_in    (single_fault_irq_enable_q),
      .double_fault_irq_enable_in    (double_fault_irq_enable_q),
      .cmd_irq_out (cmd_irq_out),
      .err_irq_out (err_irq_out)
   );
   // -------------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (launch) state_d = ST_CHECK;
         ST_CHECK: begin
            if (acc_err || prot_err || code == `DFCS_CMD_FMARGIN)
               state_d = ST_DONE;
            else if (is_ev)
               state_d = ST_VERIFY;
            else
               state_d = ST_OPER;
         end
         ST_OPER:   if (op_step && last) state_d = ST_VERIFY;
         ST_VERIFY: if (op_step && last) state_d = ST_DONE;
         ST_DONE:   state_d = ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         cur_q   <= 16'h0000;
         left_q  <= 16'h0000;
         tmr_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_q == ST_CHECK || (op_step && state_q == ST_OPER && last))
         begin
            cur_q  <= first;
            left_q <= count;
            tmr_q  <= `DFCS_OP_CYCLES;
         end else if (state_q == ST_OPER || state_q == ST_VERIFY) begin
            tmr_q <= op_step ? `DFCS_OP_CYCLES : tmr_q - 8'h01;
            if (op_step) begin
               cur_q  <= cur_q + 16'h0001;
               left_q <= left_q - 16'h0001;
            end
         end
      end
   end
   // Array: program ANDs bits low, erase restores ones.
   always_ff @(posedge clk_in) begin
      if (state_q == ST_OPER && op_step && is_pr)
         mem_q[wptr[`DFCS_DF_WORDS-1:0]] <= rword & cbuf_q[pidx];
      else if (state_q == ST_OPER && op_step && is_er)
         mem_q[wptr[`DFCS_DF_WORDS-1:0]] <= 16'hFFFF;
   end
   // -------------------------------------------------------------------------
   // Registers and flags
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         index_q <= 3'h0;
         launch_idx_q <= 3'h0;
         for (int i = 0; i < 6; i++) cbuf_q[i] <= 16'h0000;
      end else begin
         if (wr_idx) index_q <= avs_writedata_in[2:0];
         if (wr_buf && index_q <= 3'h5)
            cbuf_q[index_q] <= avs_writedata_in[15:0];
         if (launch) launch_idx_q <= index_q;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         command_complete_flag_q   <= 1'b1;
         access_error_flag_q <= 1'b0;
         pviol_q  <= 1'b0;
         verr_q   <= 1'b0;
         verru_q  <= 1'b0;
      end else begin
         if (launch) begin
            command_complete_flag_q  <= 1'b0;
            verr_q  <= 1'b0;
            verru_q <= 1'b0;
         end
         if (cmd_done) command_complete_flag_q <= 1'b1;
         if (state_q == ST_CHECK && acc_err) access_error_flag_q <= 1'b1;
         else if (wr_st && avs_writedata_in[`DFCS_ST_ACCESS_ERROR_FLAG])
            access_error_flag_q <= 1'b0;
         if (state_q == ST_CHECK && !acc_err && prot_err)
            pviol_q <= 1'b1;
         else if (wr_st && avs_writedata_in[`DFCS_ST_PVIOL])
            pviol_q <= 1'b0;
         if (verr_ev || verr_pr) verr_q <= 1'b1;
         if ((verr_ev || verr_pr) && uncorr) verru_q <= 1'b1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         command_complete_irq_enable_q  <= 1'b0;
         single_fault_irq_enable_q <= 1'b0;
         double_fault_irq_enable_q <= 1'b0;
         single_fault_flag_q <= 1'b0;
         double_fault_flag_q <= 1'b0;
      end else begin
         if (wr_cfg) begin
            command_complete_irq_enable_q  <= avs_writedata_in[`DFCS_CF_COMMAND_COMPLETE_IRQ_ENABLE];
            single_fault_irq_enable_q <= avs_writedata_in[`DFCS_CF_SINGLE_FAULT_IRQ_ENABLE];
            double_fault_irq_enable_q <= avs_writedata_in[`DFCS_CF_DOUBLE_FAULT_IRQ_ENABLE];
         end
         if ((verr_ev || verr_pr) && !uncorr) single_fault_flag_q <= 1'b1;
         else if (wr_er && avs_writedata_in[`DFCS_ER_SINGLE_FAULT_FLAG]) single_fault_flag_q <= 1'b0;
         if ((verr_ev || verr_pr) && uncorr) double_fault_flag_q <= 1'b1;
         else if (wr_er && avs_writedata_in[`DFCS_ER_DOUBLE_FAULT_FLAG]) double_fault_flag_q <= 1'b0;
      end
   end
   // Sticky event bits: 0 command done, 1 ECC fault; set wins over clear.
   wire [1:0] ev = {verr_ev || verr_pr, cmd_done};
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         irqst_q   <= 2'b00;
         irqmask_q <= 2'b00;
         irq_q     <= 1'b0;
      end else begin
         irqst_q <= ev | (irqst_q & ~(wr_is ? avs_writedata_in[1:0] : 2'b00));
         if (wr_im) irqmask_q <= avs_writedata_in[1:0];
         irq_q <= |(irqst_q & irqmask_q);
      end
   end
   // -------------------------------------------------------------------------
   // Bus answer, stop handshake, synchronisers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wait_q    <= 1'b1;
         rdata_q   <= 32'h0;
         stopack_q <= 1'b0;
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
      end else begin
         wait_q    <= !acc;
         rdata_q   <= rd_mux;
         mode_s1_q <= mode_ok_in;
         mode_s2_q <= mode_s1_q;
         stop_s1_q <= stop_req_in;
         stop_s2_q <= stop_s1_q;
         stopack_q <= stop_s2_q && command_complete_flag_q && state_q == ST_IDLE;
      end
   end
   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign stop_ack_out        = stopack_q;
   assign irq_out             = irq_q;
   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking dfcs_cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_launch;
      state_q == ST_CHECK;
   endsequence
   a_abort_fast: assert property (
      s_launch and acc_err |=> state_q == ST_DONE ##1 command_complete_flag_q)
      else $error("failed launch not completed at once");
   a_access_error_flag_set: assert property (
      s_launch and acc_err |=> access_error_flag_q)
      else $error("access error flag not set");
   a_pviol_nowrite: assert property (
      s_launch and prot_err |=> state_q != ST_OPER)
      else $error("protected area operated");
   a_stop_hold: assert property (
      !command_complete_flag_q |=> !stopack_q)
      else $error("stop granted during command");
   a_prog_count: assert property (
      s_launch and !acc_err and !prot_err and is_pr
      |=> left_q == 16'(launch_idx_q) - 16'h0001)
      else $error("program word count wrong");
   a_command_complete_flag_clear: assert property (
      launch |=> !command_complete_flag_q ##1 !command_complete_flag_q)
      else $error("launch did not clear complete flag");
   a_fm_index: assert property (
      s_launch and code == `DFCS_CMD_FMARGIN and launch_idx_q != 3'h1
      |=> access_error_flag_q)
      else $error("field margin index not checked");
   a_er_index: assert property (
      s_launch and is_er and launch_idx_q != 3'h1 |=> access_error_flag_q)
      else $error("erase index not checked");
endmodule

// *** testbench/dfcs_env_model.sv ***
// Model of the system beside the sequencer: operating mode and protection.
`timescale 1ns/1ps
module dfcs_env_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // Settings chosen by the bench
   input  wire logic        special_in,
   input  wire logic [15:0] prot_in,
   // Towards the sequencer
   output logic             mode_ok_out,
   output logic [15:0]      prot_limit_out
);
   // Settings move only on a clock edge, as the system registers would.
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         mode_ok_out    <= 1'b1;
         prot_limit_out <= 16'h0000;
      end else begin
         mode_ok_out    <= special_in;
         prot_limit_out <= prot_in;
      end
   end
endmodule

// *** testbench/test_data_flash_command_sequencer.sv ***
// Self-checking bench of the data flash command sequencer.
`timescale 1ns/1ps
`include "dfcs_params.svh"
module test_data_flash_command_sequencer;
   logic        clk_in;
   logic        nrst_in;
   logic [3:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wreq;
   logic        special;
   logic [15:0] prot;
   logic        mode_ok;
   logic [15:0] prot_lim;
   logic        stop_req;
   logic        stop_ack;
   logic        irq;
   logic        cmd_irq;
   logic        err_irq;
   logic [31:0] q;
   int          failures;
   int          cmp_count;
   localparam logic [15:0] BASE = `DFCS_DF_BASE;
   localparam logic [15:0] SEC  = BASE + 16'h0040;
   localparam logic [15:0] FM   = {`DFCS_CMD_FMARGIN, 8'h01};
   localparam logic [15:0] EV   = {`DFCS_CMD_EVSECT, 8'h01};
   localparam logic [15:0] PG   = {`DFCS_CMD_PROG, 8'h01};
   localparam logic [15:0] ER   = {`DFCS_CMD_ERASE, 8'h01};
   logic [15:0] tw0 [11] = '{FM, FM, EV, EV, EV, EV, PG, PG, PG, ER, ER};
   logic [15:0] tw1 [11] = '{16'h0000, 16'h0005, BASE, 16'h0000,
      BASE + 16'h0001, BASE, BASE, BASE + 16'h0001, BASE + 16'h07FE,
      BASE, BASE + 16'h0001};
   logic [15:0] tw2 [11] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001,
      16'h0001, 16'h0801, 16'h5555, 16'h5555, 16'h5555, 16'h0000,
      16'h0000};
   logic [2:0]  tix [11] = '{3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h1,
      3'h2, 3'h5, 3'h2, 3'h1};

   dfcs_env_model env_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .special_in(special), .prot_in(prot), .mode_ok_out(mode_ok),
      .prot_limit_out(prot_lim));
   dfcs_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .mode_ok_in(mode_ok),
      .prot_limit_in(prot_lim), .stop_req_in(stop_req),
      .stop_ack_out(stop_ack), .irq_out(irq), .cmd_irq_out(cmd_irq),
      .err_irq_out(err_irq));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // The request is held until waitrequest is sampled low at an edge.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20) begin
         failures++;
         $display("[FAIL] %0t bus answer missing", $time);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic load(input logic [15:0] w0, w1, w2, w3,
                       input logic [2:0] idx);
      logic [15:0] w [4];
      w = '{w0, w1, w2, w3};
      for (int k = 0; k < 4; k++) begin
         wreg(`DFCS_OFS_INDEX, 32'(k));
         wreg(`DFCS_OFS_BUFFER, {16'h0000, w[k]});
      end
      wreg(`DFCS_OFS_INDEX, {29'h0, idx});
      wreg(`DFCS_OFS_STATUS, 32'h0000_0080);
   endtask

   // Polls for completion; an erase of a sector lasts over a thousand cycles.
   task automatic run(input logic [15:0] w0, w1, w2, w3,
                      input logic [2:0] idx, input logic [31:0] exp);
      int n;
      load(w0, w1, w2, w3, idx);
      n = 0;
      do begin
         bus(1'b0, `DFCS_OFS_STATUS, 32'h0, q);
         n++;
      end while (q[7] !== 1'b1 && n < 400);
      check(q & 32'h0000_00B3, exp);
   endtask

   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk_in);
      failures++;
      summarize();
   end

   initial begin
      nrst_in = 1'b0;
      adr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0;
      special = 1'b1;
      prot = 16'h0000;
      stop_req = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      check({31'h0, cmd_irq}, 32'h0);
      for (int i = 0; i < 11; i++) begin
         run(tw0[i],tw1[i],tw2[i],16'h5555,tix[i],32'hA0);
         wreg(`DFCS_OFS_STATUS, 32'h20);
      end
      special <= 1'b0;
      run(FM, 16'h0000, 16'h0, 16'h0, 3'h1, 32'hA0);
      wreg(`DFCS_OFS_STATUS, 32'h20);
      special <= 1'b1;
      run(FM, 16'h0004, 16'h0, 16'h0, 3'h1, 32'h80);
      wreg(`DFCS_OFS_CONFIG, 32'h80);
      repeat (3) @(posedge clk_in);
      check({31'h0, cmd_irq}, 32'h1);
      stop_req <= 1'b1;
      load(ER, SEC, 16'h0, 16'h0, 3'h1);
      repeat (4) @(posedge clk_in);
      check({30'h0, cmd_irq, stop_ack}, 32'h0);
      run(16'h0, 16'h0, 16'h0, 16'h0, 3'h0, 32'h80);
      wreg(`DFCS_OFS_STATUS, 32'h20);
      repeat (3) @(posedge clk_in);
      check({30'h0, cmd_irq, stop_ack}, 32'h3);
      stop_req <= 1'b0;
      run(EV, SEC, 16'h0004, 16'h0, 3'h2, 32'h80);
      run(PG, SEC, 16'h1234, 16'h0000, 3'h3, 32'h80);
      run(EV, SEC, 16'h0002, 16'h0, 3'h2, 32'h83);
      bus(1'b0, `DFCS_OFS_ERRSTAT, 32'h0, q);
      check(q, 32'h3);
      wreg(`DFCS_OFS_CONFIG, 32'h83);
      repeat (3) @(posedge clk_in);
      check({31'h0, err_irq}, 32'h1);
      wreg(`DFCS_OFS_ERRSTAT, 32'h3);
      repeat (3) @(posedge clk_in);
      check({31'h0, err_irq}, 32'h0);
      run(PG, SEC + 16'h4, 16'h5678, 16'h0000, 3'h2, 32'h80);
      prot <= 16'hFFFF;
      run(PG, SEC + 16'h8, 16'h9ABC, 16'h0, 3'h2, 32'h90);
      wreg(`DFCS_OFS_STATUS, 32'h10);
      run(ER, SEC, 16'h0, 16'h0, 3'h1, 32'h90);
      wreg(`DFCS_OFS_STATUS, 32'h10);
      prot <= 16'h0000;
      check({30'h0, irq, err_irq}, 32'h0);
      wreg(`DFCS_OFS_IRQMASK, 32'h1);
      repeat (3) @(posedge clk_in);
      check({31'h0, irq}, 32'h1);
      wreg(`DFCS_OFS_IRQSTAT, 32'h1);
      repeat (3) @(posedge clk_in);
      check({31'h0, irq}, 32'h0);
      summarize();
   end
endmodule
